// *** bench/gp_pad_model.sv ***
// Purpose: pad load on the five pins, an external source plus the pin's own pulls
// Assumes: a pad that is driving wins over the external source
// Notes: a pad left floating toggles every cycle, so an even sampling period always reads it at one fixed level
`timescale 1ns/1ps
module gp_pad_model
  import gp_pkg::*;
(
  // clock
  hclk,
  // pad controls
  pad_o,
  pad_oe,
  pad_pu,
  pad_pd,
  // external source
  ext_en,
  ext_val,
  // sensed level
  pad_lvl
);
  input wire logic hclk;
  input wire logic [NPIN-1:0] pad_o;
  input wire logic [NPIN-1:0] pad_oe;
  input wire logic [NPIN-1:0] pad_pu;
  input wire logic [NPIN-1:0] pad_pd;
  input wire logic [NPIN-1:0] ext_en;
  input wire logic [NPIN-1:0] ext_val;
  output logic [NPIN-1:0] pad_lvl;
  logic flt_r = 1'b0;
  always_ff @(posedge hclk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) pad_lvl[i] = pad_o[i];
      else if (ext_en[i]) pad_lvl[i] = ext_val[i];
      else if (pad_pu[i]) pad_lvl[i] = 1'b1;
      else if (pad_pd[i]) pad_lvl[i] = 1'b0;
      else pad_lvl[i] = flt_r;
    end
  end
endmodule // gp_pad_model

// *** bench/gpio_config_and_readback_tb_top.sv ***
// Purpose: self-checking bench of the pin configuration and readback block
// Assumes: sampling every 16 cycles, pwm period of 200 cycles
// Notes: a behavioural model of pin state is compared at every read answer
`timescale 1ns/1ps
module gpio_config_and_readback_tb_top
  import gp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, resp, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] dflt_lvl, gpio_fn, gpio_in, gpio_o, gpio_oe, gpio_pu, gpio_pd, gpio_slow, ext_val;
  logic [39:0] bad [5];
  logic [4:0] lvw;
  int num_errors, tests_run, p, md, cnt;
  int m_fn[NPIN], m_mode[NPIN], m_duty[NPIN], b_fn[NPIN], b_mode[NPIN], b_duty[NPIN];
  int duty_set[3] = '{1, 25, 99};

  gp_top #(.SMP_CYC(16), .STP_CYC(2)) gp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dflt_lvl(dflt_lvl), .gpio_fn(gpio_fn),
    .gpio_in(gpio_in), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pu(gpio_pu), .gpio_pd(gpio_pd),
    .gpio_slow(gpio_slow));
  gp_pad_model gp_pad_model_i (.hclk(hclk), .pad_o(gpio_o), .pad_oe(gpio_oe), .pad_pu(gpio_pu),
    .pad_pd(gpio_pd), .ext_en(5'h1F), .ext_val(ext_val), .pad_lvl(gpio_in));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // wait for hready under a bound; running out ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask

  task automatic cmd(input logic [7:0] ty, input logic [3:0] ln, input logic [7:0] b0, b1, b2);
    ahb(1'b1, A_DATA, {8'h00, b2, b1, b0}, rd);
    ahb(1'b1, A_CMD, {20'h0_0000, ln, ty}, rd);
    ahb(1'b0, A_RESP, 32'h0000_0000, resp);
    ahb(1'b0, A_RDATA, 32'h0000_0000, rdat);
  endtask

  // {oe, o, pu, pd, slow} for a drive code and a wanted level
  function automatic logic [4:0] want(input int p);
    logic lv;
    lv = m_fn[p] ? (m_duty[p] >= 100) : dflt_lvl[p];
    case (m_mode[p])
      0: return lv ? 5'h18 : 5'h02;
      1: return {1'b1, lv, 3'h0};
      3: return lv ? 5'h04 : 5'h10;
      4: return lv ? 5'h19 : 5'h00;
      5: return {1'b1, lv, 3'h1};
      7: return lv ? 5'h00 : 5'h11;
      default: return 5'h00;
    endcase
  endfunction

  task automatic set_pin(input int pn, input logic [7:0] st, input logic [7:0] cf, input logic [3:0] ln);
    cmd(CMD_SET, ln, pn[7:0], st, cf);
    chk("set answer", resp, {1'b1, 19'h0_0000, 4'h0, CMD_SET | ACK_OR});
    m_duty[pn] = st;
    if (ln == LEN_CFG) begin
      m_fn[pn] = cf[3];
      m_mode[pn] = cf[2:0];
    end
  endtask

  task automatic rd_pin(input int pn, input logic [7:0] b1x, input bit use_b1);
    cmd(CMD_READ, LEN_RD, pn[7:0], 8'h00, 8'h00);
    chk("read answer", resp, {1'b1, 19'h0_0000, LEN_RDANS, CMD_READ | ACK_OR});
    chk("read index", rdat[7:0], pn[7:0]);
    chk("read duty", rdat[23:16], m_duty[pn][7:0]);
    chk("read config", rdat[31:24], {4'h0, m_fn[pn][0], m_mode[pn][2:0]});
    if (use_b1) chk("read flags", rdat[15:8], b1x);
  endtask

  task automatic chk_all();
    logic [4:0] e;
    for (int i = 0; i < NPIN; i++) begin
      e = want(i);
      chk("pad", {gpio_oe[i], gpio_o[i] & gpio_oe[i], gpio_pu[i], gpio_pd[i], gpio_slow[i] & gpio_oe[i]}, e);
      chk("function", gpio_fn[i], m_fn[i][0]);
      rd_pin(i, 8'h00, 1'b0);
    end
  endtask

  task automatic factory();
    for (int i = 0; i < NPIN; i++) begin
      m_fn[i] = DFLT_FN[i];
      m_mode[i] = DFLT_MODE[3*i +: 3];
      m_duty[i] = DFLT_DUTY;
    end
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_all();
  endtask

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, ext_val} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    dflt_lvl = 5'h1A;
    bad = '{40'h22_03_05_00_09, 40'h22_02_00_65_00, 40'h22_03_00_00_0E, 40'h23_01_FF_00_00, 40'h30_00_00_00_00};
    void'($urandom(71));
    factory();
    chk("okay response", hresp, 1'b0);
    repeat (30) begin
      p = $urandom_range(4);
      md = $urandom_range(7);
      if (md == 6) md = 5;
      dflt_lvl <= 5'($urandom);
      ext_val <= 5'($urandom);
      set_pin(p, $urandom_range(1) ? DUTY_MAX : 8'h00, {4'h0, 1'($urandom), md[2:0]}, 4'($urandom_range(3, 2)));
      repeat (24) @(posedge hclk);
      chk_all();
      ahb(1'b0, A_LEVEL, 32'h0000_0000, rd);
      // a driving pad shows its own value, otherwise the external source wins over the pulls
      for (int i = 0; i < NPIN; i++) begin
        lvw = want(i);
        chk("level", rd[i], lvw[4] ? lvw[3] : ext_val[i]);
      end
    end
    foreach (bad[i]) begin
      cmd(bad[i][39:32], bad[i][27:24], bad[i][23:16], bad[i][15:8], bad[i][7:0]);
      chk("refused", resp, {1'b1, 19'h0_0000, 4'h0, ERR_OR | bad[i][39:32]});
    end
    chk_all();
    set_pin(0, 8'h00, 8'h0A, LEN_CFG);
    ext_val <= 5'h00;
    repeat (40) @(posedge hclk);
    // flush edges left over from the random phase and the mode change
    rd_pin(0, 8'h00, 1'b0);
    repeat (40) @(posedge hclk);
    rd_pin(0, 8'h00, 1'b1);
    ext_val <= 5'h01;
    repeat (40) @(posedge hclk);
    rd_pin(0, 8'h05, 1'b1);
    rd_pin(0, 8'h01, 1'b1);
    ext_val <= 5'h00;
    repeat (40) @(posedge hclk);
    ext_val <= 5'h01;
    repeat (40) @(posedge hclk);
    rd_pin(0, 8'h07, 1'b1);
    foreach (duty_set[i]) begin
      set_pin(2, duty_set[i][7:0], 8'h09, LEN_CFG);
      repeat (10) @(posedge hclk);
      cnt = 0;
      repeat (200) begin
        @(posedge hclk);
        cnt += gpio_o[2] & gpio_oe[2];
      end
      chk("pwm high cycles", cnt, 2 * duty_set[i]);
    end
    ahb(1'b1, A_BOOT, 32'h0000_0001, rd);
    b_fn = m_fn;
    b_mode = m_mode;
    b_duty = m_duty;
    set_pin(2, DUTY_MAX, 8'h0C, LEN_CFG);
    ahb(1'b1, A_BOOT, 32'h0000_0002, rd);
    m_fn = b_fn;
    m_mode = b_mode;
    m_duty = b_duty;
    rd_pin(2, 8'h00, 1'b0);
    ahb(1'b0, 8'h20, 32'h0000_0000, rd);
    chk("unmapped read", rd, 32'h0000_0000);
    factory();
    complete_run();
  end
endmodule // gpio_config_and_readback_tb_top

// *** core/gp_drive.sv ***
// Purpose: pulse-width level and pad drive of one pin
// Assumes: step counts 0..99 once per pwm period
// Notes: all pad controls are registered
`timescale 1ns/1ps
module gp_drive
  import gp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin link
  gp_pin_if.drv pif
);
  logic pwm;
  logic lv;
  logic out_nxt, oe_nxt, pu_nxt, pd_nxt, slow_nxt;
  logic out_r, oe_r, pu_r, pd_r, slow_r;

  always_comb begin
    pwm = (pif.duty >= DUTY_MAX[6:0]) || (pif.step < pif.duty);
    lv = pif.fn ? pwm : pif.dflt_lvl;
    out_nxt = 1'b0;
    oe_nxt = 1'b0;
    pu_nxt = 1'b0;
    pd_nxt = 1'b0;
    slow_nxt = 1'b0;
    case (gp_mode_t'(pif.mode))
      MD_UP_PD: begin
        out_nxt = 1'b1;
        oe_nxt = lv;
        pd_nxt = !lv;
      end
      MD_STRONG: begin
        out_nxt = lv;
        oe_nxt = 1'b1;
      end
      MD_PU_DN: begin
        oe_nxt = !lv;
        pu_nxt = lv;
      end
      MD_SLOW_UP: begin
        out_nxt = 1'b1;
        oe_nxt = lv;
        slow_nxt = 1'b1;
      end
      MD_SLOW: begin
        out_nxt = lv;
        oe_nxt = 1'b1;
        slow_nxt = 1'b1;
      end
      MD_SLOW_DN: begin
        oe_nxt = !lv;
        slow_nxt = 1'b1;
      end
      default: begin
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
      pu_r <= 1'b0;
      pd_r <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      slow_r <= slow_nxt;
    end
  end

  assign pif.out = out_r;
  assign pif.oe = oe_r;
  assign pif.pu = pu_r;
  assign pif.pd = pd_r;
  assign pif.slow = slow_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_low; pif.fn && pif.duty == 7'h00 && pif.mode == MD_STRONG |=> oe_r && !out_r; endproperty
  a_low: assert property (p_low) else $error("zero level not driven low");
  property p_pwm; pif.fn && pif.mode == MD_UP_PD && pif.duty != 7'h00 && pif.step >= pif.duty
    && pif.duty < DUTY_MAX[6:0] |=> !oe_r && pd_r; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm high past duty");
  property p_high; pif.fn && pif.duty == DUTY_MAX[6:0] && pif.mode == MD_SLOW |=> oe_r && out_r && slow_r; endproperty
  a_high: assert property (p_high) else $error("full level not driven high");
  property p_hiz; pif.mode == MD_HIZ || pif.mode == MD_RSVD |=> !oe_r && !pu_r && !pd_r; endproperty
  a_hiz: assert property (p_hiz) else $error("input mode drives pin");
  property p_dflt; !pif.fn && pif.mode == MD_STRONG |=> out_r == $past(pif.dflt_lvl); endproperty
  a_dflt: assert property (p_dflt) else $error("default role level not passed");
endmodule // gp_drive

// *** core/gp_pin_if.sv ***
// Purpose: per-pin link between the control core and its drive and sense logic
// Assumes: all signals on hclk
// Notes: one instance per pin
`timescale 1ns/1ps
interface gp_pin_if;
  logic fn;
  logic [2:0] mode;
  logic [6:0] duty;
  logic [6:0] step;
  logic dflt_lvl;
  logic pad_in;
  logic tick;
  logic rd_clr;
  logic out;
  logic oe;
  logic pu;
  logic pd;
  logic slow;
  logic lvl;
  logic rise;
  logic fall;
  modport drv(input fn, mode, duty, step, dflt_lvl, output out, oe, pu, pd, slow);
  modport sns(input pad_in, tick, rd_clr, output lvl, rise, fall);
endinterface

// *** core/gp_pkg.sv ***
// Purpose: shared constants and types of the pin configuration and readback block
// Assumes: 50 MHz system clock, one aligned 32-bit word per register
// Notes: boot-state defaults stand here as reset values
package gp_pkg;
  localparam int NPIN = 5;
  localparam int CLK_HZ = 50_000_000;
  localparam int SAMPLE_HZ = 32;
  localparam int PWM_HZ = 100;
  localparam int DUTY_STEPS = 100;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int STEP_CYC = CLK_HZ / (PWM_HZ * DUTY_STEPS);
  // command codes and answer marks
  localparam logic [7:0] CMD_SET = 8'h22;
  localparam logic [7:0] CMD_READ = 8'h23;
  localparam logic [7:0] ACK_OR = 8'h40;
  localparam logic [7:0] ERR_OR = 8'hC0;
  localparam logic [7:0] DUTY_MAX = 8'h64;
  localparam logic [3:0] LEN_VAL = 4'h2;
  localparam logic [3:0] LEN_CFG = 4'h3;
  localparam logic [3:0] LEN_RD = 4'h1;
  localparam logic [3:0] LEN_RDANS = 4'h4;
  // register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_RESP = 8'h08;
  localparam logic [7:0] A_RDATA = 8'h0C;
  localparam logic [7:0] A_BOOT = 8'h10;
  localparam logic [7:0] A_LEVEL = 8'h14;
  // field positions
  localparam int CMD_LEN_LSB = 8;
  localparam int RESP_VLD_BIT = 31;
  localparam int BOOT_STORE_BIT = 0;
  localparam int BOOT_LOAD_BIT = 1;
  // factory boot state, pin 0 in the low bits
  localparam logic [NPIN-1:0] DFLT_FN = 5'h00;
  localparam logic [3*NPIN-1:0] DFLT_MODE = 15'h3252;
  localparam logic [6:0] DFLT_DUTY = 7'h00;
  typedef enum logic [2:0] {
    MD_UP_PD = 3'b000,
    MD_STRONG = 3'b001,
    MD_HIZ = 3'b010,
    MD_PU_DN = 3'b011,
    MD_SLOW_UP = 3'b100,
    MD_SLOW = 3'b101,
    MD_RSVD = 3'b110,
    MD_SLOW_DN = 3'b111
  } gp_mode_t;
endpackage

// *** core/gp_sense.sv ***
// Purpose: synchronise, sample and track edges of one pin
// Assumes: tick is one cycle wide at the sampling rate
// Notes: first sample after reset reports no edge
`timescale 1ns/1ps
module gp_sense
  import gp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin link
  gp_pin_if.sns pif
);
  logic s1_r, s2_r, lvl_r, prim_r, rise_r, fall_r;
  logic rise_set, fall_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= pif.pad_in;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_r <= 1'b0;
      prim_r <= 1'b0;
    end else if (pif.tick) begin
      lvl_r <= s2_r;
      prim_r <= 1'b1;
    end
  end

  assign rise_set = pif.tick && prim_r && s2_r && !lvl_r;
  assign fall_set = pif.tick && prim_r && !s2_r && lvl_r;

  // a new edge wins over the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      rise_r <= rise_set || (rise_r && !pif.rd_clr);
      fall_r <= fall_set || (fall_r && !pif.rd_clr);
    end
  end

  assign pif.lvl = lvl_r;
  assign pif.rise = rise_r;
  assign pif.fall = fall_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_edge; pif.tick && prim_r && s2_r != lvl_r |=> (lvl_r ? rise_r : fall_r); endproperty
  a_edge: assert property (p_edge) else $error("edge not flagged");
  property p_hold; !pif.tick |=> $stable(lvl_r); endproperty
  a_hold: assert property (p_hold) else $error("level moved between samples");
  property p_clr; pif.rd_clr && !pif.tick |=> !rise_r && !fall_r; endproperty
  a_clr: assert property (p_clr) else $error("flags survive read");
endmodule // gp_sense

// *** core/gp_top.sv ***
// Purpose: command-driven configuration and readback of five pins over AHB-Lite
// Assumes: single word transfers, zero wait states, response always OKAY
// Notes: write DATA, then CMD; answer stands in RESP and RDATA
// Operation
// - two bytes set value, three also configure
// - first byte selects pin 0..4
// - state zero drives pin low
// - states 1..99 give 100 Hz pwm duty
// - state 100 holds high, above is invalid
// - drive codes 000..011 per mode table
// - drive codes 100..111, 110 reserved
// - function bit picks default role or user
// - second byte: level, falling, rising flags
// - pins sampled about 32 Hz, free running
// - reported level is the sensed pad
// - third byte is stored requested level
// - fourth byte is function and drive mode
// - configuration saved as boot state
// - factory roles on pins 1 to 4; DFLT_FN also leaves pin 0 in its default role
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module gp_top
  import gp_pkg::*;
#(
  parameter int SMP_CYC = SAMPLE_CYC,
  parameter int STP_CYC = STEP_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // default-role logic
  input wire logic [NPIN-1:0] dflt_lvl,
  output logic [NPIN-1:0] gpio_fn,
  // pads
  input wire logic [NPIN-1:0] gpio_in,
  output logic [NPIN-1:0] gpio_o,
  output logic [NPIN-1:0] gpio_oe,
  output logic [NPIN-1:0] gpio_pu,
  output logic [NPIN-1:0] gpio_pd,
  output logic [NPIN-1:0] gpio_slow
);
  // live and boot configuration
  logic [NPIN-1:0] fn_r;
  logic [2:0] mode_r [NPIN];
  logic [6:0] duty_r [NPIN];
  logic [NPIN-1:0] bfn_r;
  logic [2:0] bmode_r [NPIN];
  logic [6:0] bduty_r [NPIN];
  // command and answer
  logic [23:0] data_r;
  logic [7:0] rtype_r;
  logic [3:0] rlen_r;
  logic rvld_r;
  logic [31:0] rdat_r;
  // bus
  logic aw_r;
  logic [7:0] aa_r;
  logic [31:0] hrdata_r;
  logic hready_r;
  logic ap;
  logic [31:0] rd_val;
  // timing
  logic [31:0] smp_cnt_r;
  logic tick_r;
  logic [31:0] stp_cnt_r;
  logic [6:0] step_r;
  // per-pin collection
  logic [NPIN-1:0] lvl_v;
  logic [NPIN-1:0] rise_v;
  logic [NPIN-1:0] fall_v;
  logic [NPIN-1:0] rclr_v;
  logic [NPIN-1:0] fn_v;
  // decode
  logic wr_cmd, wr_data, wr_boot;
  logic [7:0] c_type;
  logic [3:0] c_len;
  logic [7:0] c_idx;
  logic [7:0] c_st;
  logic [7:0] c_cf;
  logic [2:0] pidx;
  logic idx_ok, set_ok, rd_ok;
  logic [6:0] duty_sel;
  logic [3:0] cfg_sel;
  logic [2:0] flg_sel;

  // address phase taken when selected, transfer active (htrans[1]) and bus ready
  assign ap = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_r <= 1'b0;
      aa_r <= 8'h00;
    end else begin
      aw_r <= ap && hwrite;
      aa_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_r <= 1'b1;
    end else begin
      hready_r <= 1'b1;
    end
  end

  assign wr_cmd = aw_r && (aa_r == A_CMD);
  assign wr_data = aw_r && (aa_r == A_DATA);
  assign wr_boot = aw_r && (aa_r == A_BOOT);

  always_comb begin
    case (haddr[7:0])
      A_DATA: rd_val = {8'h00, data_r};
      A_RESP: rd_val = {rvld_r, 19'h0_0000, rlen_r, rtype_r};
      A_RDATA: rd_val = rdat_r;
      A_LEVEL: rd_val = {27'h000_0000, lvl_v};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ap && !hwrite) begin
      hrdata_r <= rd_val;
    end
  end

  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // command fields
  assign c_type = hwdata[7:0];
  assign c_len = hwdata[CMD_LEN_LSB +: 4];
  assign c_idx = data_r[7:0];
  assign c_st = data_r[15:8];
  assign c_cf = data_r[23:16];
  assign pidx = c_idx[2:0];
  assign idx_ok = c_idx < 8'(NPIN);
  assign set_ok = (c_type == CMD_SET) && (c_len == LEN_VAL || c_len == LEN_CFG) && idx_ok
    && (c_st <= DUTY_MAX) && !(c_len == LEN_CFG && c_cf[2:0] == MD_RSVD);
  assign rd_ok = (c_type == CMD_READ) && (c_len == LEN_RD) && idx_ok;

  always_comb begin
    duty_sel = 7'h00;
    cfg_sel = 4'h0;
    flg_sel = 3'h0;
    for (int i = 0; i < NPIN; i++) begin
      if (pidx == 3'(i)) begin
        duty_sel = duty_r[i];
        cfg_sel = {fn_r[i], mode_r[i]};
        flg_sel = {rise_v[i], fall_v[i], lvl_v[i]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= 24'h00_0000;
    end else if (wr_data) begin
      data_r <= hwdata[23:0];
    end
  end

  // live configuration starts from the factory boot state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_r <= DFLT_FN;
      for (int i = 0; i < NPIN; i++) begin
        mode_r[i] <= DFLT_MODE[3*i +: 3];
        duty_r[i] <= DFLT_DUTY;
      end
    end else if (wr_boot && hwdata[BOOT_LOAD_BIT]) begin
      fn_r <= bfn_r;
      mode_r <= bmode_r;
      duty_r <= bduty_r;
    end else if (wr_cmd && set_ok) begin
      duty_r[pidx] <= c_st[6:0];
      if (c_len == LEN_CFG) begin
        fn_r[pidx] <= c_cf[3];
        mode_r[pidx] <= c_cf[2:0];
      end
    end
  end

  // boot copy, stands in for the non-volatile store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bfn_r <= DFLT_FN;
      for (int i = 0; i < NPIN; i++) begin
        bmode_r[i] <= DFLT_MODE[3*i +: 3];
        bduty_r[i] <= DFLT_DUTY;
      end
    end else if (wr_boot && hwdata[BOOT_STORE_BIT]) begin
      bfn_r <= fn_r;
      bmode_r <= mode_r;
      bduty_r <= duty_r;
    end
  end

  // answer to every command written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtype_r <= 8'h00;
      rlen_r <= 4'h0;
      rdat_r <= 32'h0000_0000;
    end else if (wr_cmd) begin
      if (set_ok) begin
        rtype_r <= ACK_OR | c_type;
        rlen_r <= 4'h0;
        rdat_r <= 32'h0000_0000;
      end else if (rd_ok) begin
        rtype_r <= ACK_OR | c_type;
        rlen_r <= LEN_RDANS;
        rdat_r <= {4'h0, cfg_sel, 1'b0, duty_sel, 5'h00, flg_sel, c_idx};
      end else begin
        rtype_r <= ERR_OR | c_type;
        rlen_r <= 4'h0;
        rdat_r <= 32'h0000_0000;
      end
    end
  end

  // valid flag: a new answer wins over the read that clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rvld_r <= 1'b0;
    end else if (wr_cmd) begin
      rvld_r <= 1'b1;
    end else if (ap && !hwrite && haddr[7:0] == A_RESP) begin
      rvld_r <= 1'b0;
    end
  end

  // free running sample tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (smp_cnt_r == 32'(SMP_CYC - 1)) begin
      smp_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      smp_cnt_r <= smp_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // duty step, 100 steps per pwm period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stp_cnt_r <= 32'h0000_0000;
      step_r <= 7'h00;
    end else if (stp_cnt_r == 32'(STP_CYC - 1)) begin
      stp_cnt_r <= 32'h0000_0000;
      step_r <= (step_r == 7'(DUTY_STEPS - 1)) ? 7'h00 : step_r + 7'h01;
    end else begin
      stp_cnt_r <= stp_cnt_r + 32'h0000_0001;
    end
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    gp_pin_if pif();
    assign pif.fn = fn_r[g];
    assign pif.mode = mode_r[g];
    assign pif.duty = duty_r[g];
    assign pif.step = step_r;
    assign pif.dflt_lvl = dflt_lvl[g];
    assign pif.pad_in = gpio_in[g];
    assign pif.tick = tick_r;
    assign pif.rd_clr = rclr_v[g];
    assign rclr_v[g] = wr_cmd && rd_ok && (pidx == 3'(g));
    gp_drive u_drv (
      .hclk(hclk),
      .hresetn(hresetn),
      .pif(pif.drv)
    );
    gp_sense u_sns (
      .hclk(hclk),
      .hresetn(hresetn),
      .pif(pif.sns)
    );
    assign gpio_o[g] = pif.out;
    assign gpio_oe[g] = pif.oe;
    assign gpio_pu[g] = pif.pu;
    assign gpio_pd[g] = pif.pd;
    assign gpio_slow[g] = pif.slow;
    assign lvl_v[g] = pif.lvl;
    assign rise_v[g] = pif.rise;
    assign fall_v[g] = pif.fall;
  end

  // function bits leave from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_v <= DFLT_FN;
    end else begin
      fn_v <= fn_r;
    end
  end

  assign gpio_fn = fn_v;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ack;
    wr_cmd && set_ok |=> rtype_r == (ACK_OR | $past(c_type)) && rlen_r == 4'h0 && rvld_r;
  endproperty
  a_ack: assert property (p_ack) else $error("set answer wrong");

  property p_val_only;
    wr_cmd && set_ok && c_len == LEN_VAL |=> $stable(fn_r);
  endproperty
  a_val_only: assert property (p_val_only) else $error("value-only set changed function");

  property p_bad_idx;
    wr_cmd && !idx_ok |=> rtype_r[7:6] == 2'b11 && $stable(duty_r[0]);
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("reserved index accepted");

  property p_rd_idx;
    wr_cmd && rd_ok |=> rdat_r[7:0] == $past(c_idx) && rlen_r == LEN_RDANS;
  endproperty
  a_rd_idx: assert property (p_rd_idx) else $error("read answer index wrong");

  property p_rd_lvl;
    wr_cmd && rd_ok |=> rdat_r[23:16] == {1'b0, $past(duty_sel)};
  endproperty
  a_rd_lvl: assert property (p_rd_lvl) else $error("requested level not returned");

  property p_rd_cfg;
    wr_cmd && rd_ok |=> rdat_r[31:24] == {4'h0, $past(cfg_sel)} && rdat_r[15:11] == 5'h00;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("configuration byte wrong");

  property p_store;
    wr_boot && hwdata[BOOT_STORE_BIT] |=> bfn_r == $past(fn_r);
  endproperty
  a_store: assert property (p_store) else $error("boot state not stored");
endmodule // gp_top
